/* verilog/window_watchdog_supervisor.sv */
/*
 * Windowed watchdog and voltage-monitor reset sequencer.
 * Assumes monitor_in is the digital comparator output (high = above
 * threshold), asynchronous to sys_clk; watchdog_clear_n from the processor
 * pin. sys_rst_n drives an open-drain pin: oe low pulls it low.
 */
`timescale 1ns/1ps
module window_watchdog_supervisor
	import wdsup_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
	parameter int unsigned OPEN_PCT      = OPEN_FRACTION_PCT,
	parameter int unsigned PULSE_DIV     = PULSE_DIVISOR,
	parameter int unsigned SENSE_CYCLES  = SENSE_CYC
)(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic monitor_in,
	input  wire logic watchdog_clear_n,
	output logic      sys_rst_n,
	output logic      sys_rst_n_oe,
	output logic      wd_open
);
	// window lengths all derived from one period
	localparam int unsigned OPEN_HALF  = (PERIOD_CYCLES / PCT_FULL) * OPEN_PCT;
	localparam int unsigned CLOSED_LEN = PERIOD_CYCLES - OPEN_HALF;
	localparam int unsigned OPEN_LEN   = 2 * OPEN_HALF;
	localparam int unsigned PULSE_LEN  = PERIOD_CYCLES / PULSE_DIV;
	localparam logic [CNT_W-1:0] CLOSED_LAST = CNT_W'(CLOSED_LEN - 1);
	localparam logic [CNT_W-1:0] OPEN_LAST   = CNT_W'(OPEN_LEN - 1);
	localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_LEN - 1);
	localparam logic [CNT_W-1:0] POR_LAST    = CNT_W'(PERIOD_CYCLES - 1);
	localparam logic [CNT_W-1:0] SENSE_LAST  = CNT_W'(SENSE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

	typedef struct packed {
		logic [1:0]       mon_sync;
		logic             mon_ok;
		logic [CNT_W-1:0] low_cnt;
		wd_state_t        st;
		logic [CNT_W-1:0] cnt;
		logic             rst_low;
	} sup_state_t;
	sup_state_t state_reg;
	sup_state_t state_next;

	logic clr_level;
	logic clr_fall;

	sync_fall u_clr (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.pin_n   (watchdog_clear_n),
		.level   (clr_level),
		.fall    (clr_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		state_next          = state_reg;
		state_next.mon_sync = {state_reg.mon_sync[0], monitor_in};
		// drop must persist for the sense time; shorter glitches ignored
		if (state_reg.mon_sync[1]) begin
			state_next.low_cnt = '0;
			state_next.mon_ok  = 1'b1;
		end else if (state_reg.low_cnt >= SENSE_LAST) begin
			state_next.mon_ok = 1'b0;
		end else begin
			state_next.low_cnt = state_reg.low_cnt + CNT_ONE;
		end
		state_next.cnt = state_reg.cnt + CNT_ONE;
		unique case (state_reg.st)
			// held in reset; clears ignored here
			ST_POR: begin
				state_next.rst_low = 1'b1;
				if (!state_reg.mon_ok)
					state_next.cnt = '0;
				else if (state_reg.cnt == POR_LAST) begin
					state_next.st      = ST_CLOSED;
					state_next.cnt     = '0;
					state_next.rst_low = 1'b0;
				end
			end
			ST_CLOSED: begin
				// an edge in the last closed cycle is a valid service, not an early one
				if (clr_fall && state_reg.cnt == CLOSED_LAST) begin
					state_next.st  = ST_CLOSED;
					state_next.cnt = '0;
				end else if (clr_fall) begin
					state_next.st      = ST_PULSE;
					state_next.cnt     = '0;
					state_next.rst_low = 1'b1;
				end else if (state_reg.cnt == CLOSED_LAST) begin
					state_next.st  = ST_OPEN;
					state_next.cnt = '0;
				end
			end
			ST_OPEN: begin
				if (clr_fall) begin
					state_next.st  = ST_CLOSED;
					state_next.cnt = '0;
				end else if (state_reg.cnt == OPEN_LAST) begin
					state_next.st      = ST_PULSE;
					state_next.cnt     = '0;
					state_next.rst_low = 1'b1;
				end
			end
			ST_PULSE: begin
				if (state_reg.cnt == PULSE_LAST) begin
					state_next.st      = ST_CLOSED;
					state_next.cnt     = '0;
					state_next.rst_low = 1'b0;
				end
			end
		endcase
		// monitor drop beats everything
		if (!state_reg.mon_ok) begin
			state_next.st      = ST_POR;
			state_next.cnt     = '0;
			state_next.rst_low = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			state_reg <= '{mon_sync: 2'h0, mon_ok: 1'b0, low_cnt: '0, st: ST_POR, cnt: '0, rst_low: 1'b1};
		else if (clk_en)
			state_reg <= state_next;
	end

	// open drain: enable low pulls the pin low
	assign sys_rst_n    = 1'b0;
	assign sys_rst_n_oe = ~state_reg.rst_low;
	assign wd_open      = (state_reg.st == ST_OPEN);

	////////////////////////////////////////////////////////////////////////
	// checks

	a_por_holds_reset: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg.st == ST_POR) |-> !sys_rst_n_oe) else $error("reset released during power-up");
	a_drop_forces_por: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && !state_reg.mon_ok) |=> (state_reg.st == ST_POR)) else $error("monitor drop not obeyed");
	a_por_restart: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.st == ST_POR && !state_reg.mon_ok) |=> (state_reg.cnt == '0)) else $error("delay not restarted");
	a_por_release: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(sys_rst_n_oe) && $past(state_reg.st) == ST_POR |-> $past(state_reg.cnt) == POR_LAST) else $error("early release");
	a_early_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.mon_ok && state_reg.st == ST_CLOSED && clr_fall && state_reg.cnt != CLOSED_LAST)
		|=> (state_reg.st == ST_PULSE && !sys_rst_n_oe)) else $error("early clear not punished");
	a_open_service: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.mon_ok && state_reg.st == ST_OPEN && clr_fall)
		|=> (state_reg.st == ST_CLOSED && sys_rst_n_oe)) else $error("service not accepted");
	a_timeout_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.mon_ok && state_reg.st == ST_OPEN && !clr_fall && state_reg.cnt == OPEN_LAST)
		|=> (state_reg.st == ST_PULSE)) else $error("missed timeout");
	a_pulse_length: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg.st == ST_PULSE) |-> (state_reg.cnt <= PULSE_LAST && !sys_rst_n_oe)) else $error("pulse too long");
	a_closed_length: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg.st == ST_CLOSED) |-> (state_reg.cnt <= CLOSED_LAST)) else $error("closed window overrun");
	a_open_length: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg.st == ST_OPEN) |-> (state_reg.cnt <= OPEN_LAST)) else $error("open window overrun");
	// boundary edge must restart the timer with reset released
	a_boundary_service: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.mon_ok && state_reg.st == ST_CLOSED && clr_fall && state_reg.cnt == CLOSED_LAST)
		|=> (state_reg.st == ST_CLOSED && state_reg.cnt == '0 && sys_rst_n_oe)) else $error("boundary service lost");
	a_por_ignores_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.st == ST_POR && state_reg.cnt != POR_LAST) |=> (state_reg.st == ST_POR))
		else $error("power-up delay cut short");
	a_pulse_release: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.mon_ok && state_reg.st == ST_PULSE && state_reg.cnt == PULSE_LAST)
		|=> (state_reg.st == ST_CLOSED && sys_rst_n_oe)) else $error("pulse not ended");
	// enable low must hold every counter, or windows would drift
	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!clk_en |=> $stable(state_reg)) else $error("state moved while frozen");
	a_glitch_filter: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg.mon_ok && state_reg.mon_sync[1]) |=> state_reg.mon_ok) else $error("monitor false trip");
endmodule : window_watchdog_supervisor

/* common/wdsup_pkg.sv */
/*
 * Constants for the windowed watchdog supervisor: timing figures in their
 * own units, cycle counts derived from them at the system clock rate.
 * Assumes a 100 MHz sys_clk standing in for the resistor-tuned time base.
 */
// How it works
// - hold reset low while monitor is low
// - keep reset low one period after recovery
// - any dropout restarts the full delay
// - monitor drop forces power-down reset
// - filter monitor drops shorter than 5 us
// - all timings from one time base
// - closed window starts at timer restart
// - open window follows, twice fraction long
// - missed service gives one short pulse
// - early clear resets and restarts timeout
// - clears ignored until power-up delay ends
// - unserviced cycles repeat until valid service
// - monitor drop overrides watchdog at once
package wdsup_pkg;
	localparam int unsigned CLK_PERIOD_PS       = 10000;
	localparam longint unsigned PERIOD_MS       = 100;
	localparam int unsigned PULSE_DIVISOR       = 40;
	localparam int unsigned OPEN_FRACTION_PCT   = 20;
	localparam int unsigned PCT_FULL            = 100;
	localparam longint unsigned SENSE_US        = 5;
	localparam longint unsigned PS_PER_MS       = 64'd1000000000;
	localparam longint unsigned PS_PER_US       = 64'd1000000;
	// cycle counts; the period rounds down, filter time rounds up
	localparam int unsigned PERIOD_CYC = int'((PERIOD_MS * PS_PER_MS) / CLK_PERIOD_PS);
	localparam int unsigned SENSE_CYC  = int'((SENSE_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int unsigned CNT_W      = 32;
	localparam logic [1:0] SYNC_INIT   = 2'h3;
	typedef enum logic [1:0] {
		ST_POR    = 2'b00,
		ST_CLOSED = 2'b01,
		ST_OPEN   = 2'b10,
		ST_PULSE  = 2'b11
	} wd_state_t;
endpackage : wdsup_pkg

/* verilog/sync_fall.sv */
/*
 * Two-flop synchroniser with falling-edge detect on the clear input.
 * Assumes the input idles high and pulses last well over two cycles.
 */
`timescale 1ns/1ps
module sync_fall
	import wdsup_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic pin_n,
	output logic      level,
	output logic      fall
);
	typedef struct packed {
		logic [1:0] sync;
		logic       last;
	} sf_state_t;
	sf_state_t state_reg;
	sf_state_t state_next;

	// first flop only feeds the second
	always_comb begin
		state_next      = state_reg;
		state_next.sync = {state_reg.sync[0], pin_n};
		state_next.last = state_reg.sync[1];
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			state_reg <= '{sync: SYNC_INIT, last: 1'b1};
		else if (clk_en)
			state_reg <= state_next;
	end

	assign level = state_reg.sync[1];
	assign fall  = clk_en & state_reg.last & ~state_reg.sync[1];
endmodule : sync_fall

/* test/cpu_model.sv */
/* processor stand-in driving the clear pin.
 * assumes go is a one-cycle request from the bench. */
`timescale 1ns/1ps
module cpu_model (
	input  wire logic sys_clk,
	input  wire logic go,
	output logic      clear_n
);
	int cnt = 0;
	// low for 4 cycles, well over the sync depth; idles high like the pull-up
	always @(posedge sys_clk) begin
		if (go)
			cnt <= 4;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign clear_n = (cnt == 0);
endmodule : cpu_model

/* test/window_watchdog_supervisor_tb.sv */
/* bench for the supervisor: power-up, timeout, service, early clear, brown-out.
 * assumes short cycle counts set by parameter at the instance. */
`timescale 1ns/1ps
module window_watchdog_supervisor_tb;
	localparam int P  = 1000;
	localparam int CW = P - P / 5;
	localparam int OW = 2 * (P / 5);
	localparam int PW = P / 40;
	logic sys_clk = 0, rst = 1, mon = 0, go = 0, en = 1;
	logic clr_n, pin, oe, wd_open;
	int   failures = 0, checks = 0, n;
	////////////////////////////////////////////////////////////////
	// clock and watchdog; a hang counts as a mismatch
	always #5 sys_clk = ~sys_clk;
	initial begin
		#200us;
		failures++;
		summarize();
	end
	window_watchdog_supervisor #(.PERIOD_CYCLES(P), .SENSE_CYCLES(5)) window_watchdog_supervisor_inst (
		.sys_clk(sys_clk), .rst(rst), .clk_en(en), .monitor_in(mon),
		.watchdog_clear_n(clr_n), .sys_rst_n(pin), .sys_rst_n_oe(oe), .wd_open(wd_open));
	cpu_model cpu_model_inst (.sys_clk(sys_clk), .go(go), .clear_n(clr_n));
	////////////////////////////////////////////////////////////////
	// helpers; inputs move 1 ns after the edge
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic svc;
		go = 1;
		cyc(1);
		go = 0;
	endtask : svc
	task automatic chk(input string what, input int lo, input int hi, input int seen);
		checks++;
		if (seen < lo || seen > hi) begin
			failures++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask : chk
	// bounded wait on oe (sel 0) or wd_open (sel 1)
	task automatic wt(input bit sel, input logic v, input int max);
		n = 0;
		while (((sel ? wd_open : oe) !== v) && n < max) begin
			cyc(1);
			n++;
		end
	endtask : wt
	////////////////////////////////////////////////////////////////
	task automatic t_por;
		cyc(20);
		chk("held low", 0, 0, int'(oe !== 1'b0));
		mon = 1;
		cyc(P / 2);
		svc();
		wt(0, 1, P);
		chk("power-up delay", P / 2 - 3, P / 2 + 6, n);
		$display("t_por done");
	endtask : t_por
	task automatic t_timeout;
		wt(1, 1, P);
		chk("closed window", CW - 2, CW + 2, n);
		wt(0, 0, P);
		chk("open window", OW - 2, OW + 2, n);
		wt(0, 1, P);
		chk("pulse width", PW - 1, PW + 1, n);
		wt(1, 1, P);
		chk("repeat", CW - 2, CW + 2, n);
		$display("t_timeout done");
	endtask : t_timeout
	// clear edge seen in the last closed cycle must count as a service
	task automatic t_edge;
		wt(0, 0, P);
		wt(0, 1, P);
		cyc(CW - 4);
		svc();
		cyc(5);
		chk("boundary service", 0, 0, int'(wd_open !== 1'b0 || oe !== 1'b1));
		wt(1, 1, P);
		chk("boundary restart", CW - 6, CW - 2, n);
		$display("t_edge done");
	endtask : t_edge
	// enable low stretches the closed window by the frozen span
	task automatic t_freeze;
		chk("pin drive", 0, 0, int'(pin !== 1'b0));
		en = 0;
		cyc(100);
		en = 1;
		wt(1, 1, 2 * P);
		chk("frozen closed", CW - 2, CW + 2, n);
		$display("t_freeze done");
	endtask : t_freeze
	task automatic t_service;
		cyc(OW / 2);
		svc();
		wt(0, 0, CW + OW / 2);
		chk("serviced", CW + OW / 2, CW + OW / 2, n);
		svc();
		cyc(100);
		svc();
		wt(0, 0, 20);
		chk("early clear", 2, 6, n);
		wt(0, 1, P);
		wt(1, 1, P);
		chk("restart", CW - 2, CW + 2, n);
		$display("t_service done");
	endtask : t_service
	task automatic t_brown;
		mon = 0;
		cyc(3);
		mon = 1;
		cyc(20);
		chk("short drop", 1, 1, int'(oe === 1'b1));
		mon = 0;
		wt(0, 0, 30);
		chk("drop trip", 4, 12, n);
		svc();
		cyc(10);
		mon = 1;
		wt(0, 1, 2 * P);
		chk("delay again", P, P + 8, n);
		$display("t_brown done");
	endtask : t_brown
	////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// main sequence
	initial begin
		cyc(3);
		rst = 0;
		t_por();
		t_timeout();
		t_edge();
		t_service();
		t_brown();
		t_freeze();
		summarize();
	end
endmodule : window_watchdog_supervisor_tb
